// [inc/reset_ctrl_params.svh]
// Register offsets, field positions, reset values and timing counts of the reset controller.
`ifndef RESET_CTRL_PARAMS_SVH
`define RESET_CTRL_PARAMS_SVH

`define RC_CLK_PERIOD_NS        20
`define RC_CAUSE_OFFSET         4'h0
`define RC_WDOG_OFFSET          4'h4
`define RC_REF_OFFSET           4'h8

`define RC_FLAG_POWER_ON        0
`define RC_FLAG_PIN             1
`define RC_FLAG_BROWNOUT        2
`define RC_FLAG_WDOG            3
`define RC_FLAG_SCAN            4

`define RC_WD_PERIOD_LSB        0
`define RC_WD_ENABLE_BIT        3
`define RC_WD_CHANGE_BIT        4
`define RC_REF_CMP_BIT          0

`define RC_CAUSE_RESET          5'h01
`define RC_WDCTL_RESET          5'h00
`define RC_WDOG_CHANGE_ENABLE_HOLD_CYCLES     3'h4
`define RC_WDOG_BASE_CYCLES     16384
`define RC_EXT_MIN_PULSE_NS     2500
`define RC_EXT_MIN_CYCLES       ((`RC_EXT_MIN_PULSE_NS + `RC_CLK_PERIOD_NS - 1) / `RC_CLK_PERIOD_NS)
`define RC_BOD_MIN_NS           2000
`define RC_BOD_MIN_CYCLES       ((`RC_BOD_MIN_NS + `RC_CLK_PERIOD_NS - 1) / `RC_CLK_PERIOD_NS)

`endif

// [inc/reset_ctrl_pkg.sv]
// Types shared by the reset controller.
package reset_ctrl_pkg;

  typedef struct packed {
    logic       change_enable;
    logic       enable;
    logic [2:0] period;
  } wdog_ctl_s;

  typedef struct packed {
    logic scan;
    logic wdog;
    logic brownout;
    logic pin;
    logic power_on;
  } cause_s;

endpackage

// [rtl/reset_and_watchdog_control.sv]
// Reset combiner, start-up delay, watchdog and reference enable with a Wishbone register port.
//
// Overview of operation
// - Internal reset returns control registers to initial values; CPU restarts at reset vector.
// - Power-on, pin, brown-out and scan reset force the port reset output at once, with no clock; watchdog reset needs a clock edge.
// - After all sources go inactive, internal reset stays for the fuse-chosen delay.
// - Power-on, pin, watchdog, brown-out and scan reset combine into the internal reset.
// - Pin low longer than the minimum width resets; shorter pulses may be ignored.
// - Pin release starts the delay counter; processor released when it expires.
// - Supply below power-on level resets at once; rising past it starts the delay.
// - Enabled brown-out resets at once on a drop, delay starts when supply recovers.
// - Brown-out dips shorter than the minimum detection time are ignored by the internal reset; the port reset still follows them.
// - Internal reset held while the scan reset register holds one.
// - Watchdog time-out gives a one-cycle reset pulse; delay starts after it.
// - Watchdog counter advances on its own 1 MHz oscillator, not the system clock.
// - Watchdog counter clears on restart, on disable and on any chip reset.
// - Eight periods; expiry without restart resets the device.
// - Always-on fuse unprogrammed gives level 1, programmed gives level 2 (always enabled).
// - At level 1 writing enable as one is accepted at any time.
// - At level 1 disable or retime needs arm write then second write within four cycles.
// - At level 2 enable reads one; retime needs the sequence, written enable ignored.
// - Bandgap on when brown-out enabled, comparator select set or ADC enabled.
// - Cause flags set on their reset, clear on power-on or zero write; power-on by write only.
// - Change-enable clears itself four cycles after being written one.
// - Period code 0 selects 16K oscillator cycles, doubling up to 2048K at code 7.
//
// Register access over Wishbone and the register addresses were left to the implementer.
`include "reset_ctrl_params.svh"

module reset_and_watchdog_control #(
  parameter int unsigned DELAY_BASE_CYCLES = 4096
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        por_active_i,
  input  wire logic        ext_reset_n_i,
  input  wire logic        brownout_enable_i,
  input  wire logic        brownout_low_i,
  input  wire logic        scan_reset_reg_i,
  input  wire logic        wdog_osc_i,
  input  wire logic        wdog_restart_i,
  input  wire logic        wdog_always_on_fuse_i,
  input  wire logic [1:0]  startup_time_fuse_i,
  input  wire logic [3:0]  clock_select_fuse_i,
  input  wire logic        adc_enable_i,
  output logic             io_reset_o,
  output logic             internal_reset_o,
  output logic             wdog_reset_o,
  output logic             bandgap_enable_o
);

  localparam logic [7:0]  EXT_MIN = 8'(`RC_EXT_MIN_CYCLES);
  localparam logic [7:0]  BOD_MIN = 8'(`RC_BOD_MIN_CYCLES);
  // One bit wider than the counter, so that code seven does not wrap the limit to zero.
  localparam logic [21:0] WD_BASE = 22'(`RC_WDOG_BASE_CYCLES);
  localparam logic [19:0] DLY_BASE = 20'(DELAY_BASE_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Source filtering and combination.

  logic [7:0]  ext_cnt_reg;
  logic        ext_active_reg;
  logic [7:0]  bod_cnt_reg;
  logic        bod_active_reg;
  logic        wdog_pulse_reg;
  logic        any_source;
  logic        async_source;
  logic [19:0] delay_cnt_reg;
  logic [19:0] delay_len;
  logic        internal_reset_reg;
  logic        io_reset_reg;

  // Short pin glitches are not guaranteed to reset, so only held lows count.
  always_ff @(posedge clk_i) begin
    if (rst_i || ext_reset_n_i) begin
      ext_cnt_reg    <= 8'h00;
      ext_active_reg <= 1'b0;
    end else if (ext_cnt_reg >= EXT_MIN - 8'h01) begin
      ext_active_reg <= 1'b1;
    end else begin
      ext_cnt_reg <= ext_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !brownout_enable_i || !brownout_low_i) begin
      bod_cnt_reg    <= 8'h00;
      bod_active_reg <= 1'b0;
    end else if (bod_cnt_reg >= BOD_MIN - 8'h01) begin
      bod_active_reg <= 1'b1;
    end else begin
      bod_cnt_reg <= bod_cnt_reg + 8'h01;
    end
  end

  // Level sources act through the port reset with no clock needed.
  assign async_source = por_active_i | ~ext_reset_n_i | (brownout_enable_i & brownout_low_i) | scan_reset_reg_i;
  assign any_source   = por_active_i | ext_active_reg | bod_active_reg | scan_reset_reg_i | wdog_pulse_reg;

  // Fuse-decoded stretch; external clock selection keeps the shortest delay.
  assign delay_len = (clock_select_fuse_i == 4'h0) ? DLY_BASE : (DLY_BASE << startup_time_fuse_i);

  always_ff @(posedge clk_i) begin
    if (rst_i || any_source) begin
      delay_cnt_reg      <= 20'h00000;
      internal_reset_reg <= 1'b1;
    end else if (delay_cnt_reg < delay_len) begin
      delay_cnt_reg      <= delay_cnt_reg + 20'h00001;
      internal_reset_reg <= 1'b1;
    end else begin
      internal_reset_reg <= 1'b0;
    end
  end

  // The asynchronous preset only ever loads a constant; release follows the stretched reset.
  always_ff @(posedge clk_i or posedge async_source) begin
    if (async_source) begin
      io_reset_reg <= 1'b1;
    end else begin
      io_reset_reg <= internal_reset_reg | rst_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog control and counter.

  reset_ctrl_pkg::wdog_ctl_s wd_reg;
  logic [2:0]  wdog_change_enable_timer_reg;
  logic        level2;
  logic        wd_enabled;
  logic [2:0]  osc_sync_reg;
  logic        osc_tick;
  logic [20:0] wd_cnt_reg;
  logic [20:0] wd_limit;
  logic        bus_write;
  logic        bus_hit;
  logic        wd_wr;
  logic [7:0]  wdata;

  assign level2     = wdog_always_on_fuse_i;
  assign wd_enabled = level2 | wd_reg.enable;
  assign bus_hit    = cyc_i & stb_i & ack_o;
  assign bus_write  = bus_hit & we_i & sel_i[0];
  assign wdata      = dat_i[7:0];
  assign wd_wr      = bus_write && (adr_i == `RC_WDOG_OFFSET);

  // The second stage alone feeds the third, so the edge detector never sees a metastable stage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_sync_reg <= 3'h0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[1:0], wdog_osc_i};
    end
  end
  assign osc_tick = osc_sync_reg[1] & ~osc_sync_reg[2];

  always_ff @(posedge clk_i) begin
    if (rst_i || internal_reset_reg) begin
      wd_reg         <= reset_ctrl_pkg::wdog_ctl_s'(`RC_WDCTL_RESET);
      wdog_change_enable_timer_reg <= 3'h0;
    end else if (wd_wr && wdata[`RC_WD_CHANGE_BIT] && wdata[`RC_WD_ENABLE_BIT]) begin
      wd_reg.change_enable <= 1'b1;
      wd_reg.enable        <= 1'b1;
      wdog_change_enable_timer_reg       <= `RC_WDOG_CHANGE_ENABLE_HOLD_CYCLES;
    end else if (wd_wr && wd_reg.change_enable && !wdata[`RC_WD_CHANGE_BIT]) begin
      wd_reg.change_enable <= 1'b0;
      wd_reg.period        <= wdata[`RC_WD_PERIOD_LSB +: 3];
      wd_reg.enable        <= level2 | wdata[`RC_WD_ENABLE_BIT];
      wdog_change_enable_timer_reg       <= 3'h0;
    end else begin
      if (wd_wr && wdata[`RC_WD_ENABLE_BIT]) begin
        wd_reg.enable <= 1'b1;
      end
      if (wdog_change_enable_timer_reg > 3'h1) begin
        wdog_change_enable_timer_reg <= wdog_change_enable_timer_reg - 3'h1;
      end else if (wdog_change_enable_timer_reg == 3'h1) begin
        wdog_change_enable_timer_reg       <= 3'h0;
        wd_reg.change_enable <= 1'b0;
      end
    end
  end

  assign wd_limit = 21'((WD_BASE << wd_reg.period) - 22'h000001);

  always_ff @(posedge clk_i) begin
    if (rst_i || internal_reset_reg || wdog_restart_i || !wd_enabled) begin
      wd_cnt_reg     <= 21'h000000;
      wdog_pulse_reg <= 1'b0;
    end else if (osc_tick && wd_cnt_reg >= wd_limit) begin
      wd_cnt_reg     <= 21'h000000;
      wdog_pulse_reg <= 1'b1;
    end else begin
      wdog_pulse_reg <= 1'b0;
      if (osc_tick) begin
        wd_cnt_reg <= wd_cnt_reg + 21'h000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause flags, reference enable and bus slave.

  reset_ctrl_pkg::cause_s cause_reg;
  reset_ctrl_pkg::cause_s cause_set;
  logic                   cmp_bandgap_reg;
  logic                   bandgap_reg;
  logic                   ack_reg;
  logic [31:0]            dat_reg;
  logic                   cause_wr;

  assign cause_wr  = bus_write && (adr_i == `RC_CAUSE_OFFSET);
  assign cause_set = '{scan: scan_reset_reg_i, wdog: wdog_pulse_reg, brownout: bod_active_reg,
                       pin: ext_active_reg, power_on: por_active_i};

  // A cause arriving in the cycle of a zero write still sets its flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_reg <= reset_ctrl_pkg::cause_s'(`RC_CAUSE_RESET);
    end else if (por_active_i) begin
      cause_reg <= reset_ctrl_pkg::cause_s'(`RC_CAUSE_RESET);
    end else if (cause_wr) begin
      cause_reg <= (cause_reg & reset_ctrl_pkg::cause_s'(wdata[4:0])) | cause_set;
    end else begin
      cause_reg <= cause_reg | cause_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || internal_reset_reg) begin
      cmp_bandgap_reg <= 1'b0;
    end else if (bus_write && (adr_i == `RC_REF_OFFSET)) begin
      cmp_bandgap_reg <= wdata[`RC_REF_CMP_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bandgap_reg <= 1'b0;
    end else begin
      bandgap_reg <= brownout_enable_i | cmp_bandgap_reg | adc_enable_i;
    end
  end

  // One wait state: ack and read data come one edge after the request is seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= cyc_i & stb_i & ~ack_reg;
      if (cyc_i && stb_i && !ack_reg) begin
        case (adr_i)
          `RC_CAUSE_OFFSET: dat_reg <= {27'h0000000, cause_reg};
          `RC_WDOG_OFFSET:  dat_reg <= {27'h0000000, wd_reg.change_enable, wd_enabled, wd_reg.period};
          `RC_REF_OFFSET:   dat_reg <= {31'h00000000, cmp_bandgap_reg};
          default:          dat_reg <= 32'h00000000;
        endcase
      end
    end
  end

  assign dat_o            = dat_reg;
  assign ack_o            = ack_reg;
  assign io_reset_o       = io_reset_reg;
  assign internal_reset_o = internal_reset_reg;
  assign wdog_reset_o     = wdog_pulse_reg;
  assign bandgap_enable_o = bandgap_reg;

endmodule

// [tb/reset_and_watchdog_control_bench.sv]
// Self-checking bench for the reset controller.
module reset_and_watchdog_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = 8;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, por_active_i, ext_reset_n_i, wdog_osc_i;
  logic        brownout_enable_i, brownout_low_i, scan_reset_reg_i, wdog_restart_i;
  logic        wdog_always_on_fuse_i, adc_enable_i, io_reset_o, internal_reset_o;
  logic        wdog_reset_o, bandgap_enable_o;
  logic [3:0]  adr_i, sel_i, clock_select_fuse_i;
  logic [1:0]  startup_time_fuse_i;
  logic [31:0] dat_i, dat_o, q;
  int          n_fail, check_count, cyc_n, n;
  reset_and_watchdog_control #(.DELAY_BASE_CYCLES(DLY)) i_reset_and_watchdog_control (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .por_active_i, .ext_reset_n_i, .brownout_enable_i,
    .brownout_low_i, .scan_reset_reg_i, .wdog_osc_i, .wdog_restart_i, .wdog_always_on_fuse_i,
    .startup_time_fuse_i, .clock_select_fuse_i, .adc_enable_i, .io_reset_o, .internal_reset_o, .wdog_reset_o,
    .bandgap_enable_o);
  wdog_osc_model i_wdog_osc_model (.osc_o(wdog_osc_i));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic end_sim;
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 90000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, 24'h000000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    wb(1'b0, a, 8'h00);
    chk(nm, {24'h000000, e}, q);
  endtask
  task automatic rel;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (internal_reset_o !== 1'b0 && n < 500);
  endtask
  // Pulses one source, then checks whether it reset and how long the stretch lasted.
  task automatic pulse(input int k, input int len, input logic e);
    case (k)
      0: ext_reset_n_i <= 1'b0;
      1: brownout_low_i <= 1'b1;
      2: scan_reset_reg_i <= 1'b1;
      default: por_active_i <= 1'b1;
    endcase
    repeat (len) @(posedge clk_i);
    {ext_reset_n_i, brownout_low_i, scan_reset_reg_i, por_active_i} <= 4'h8;
    repeat (4) @(posedge clk_i);
    chk("internal_reset", e, internal_reset_o);
    rel();
    if (e) chk("delay", 1'b1, n >= DLY - 4 && n <= DLY + 6);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {cyc_i, stb_i, we_i, adr_i, dat_i, clock_select_fuse_i, startup_time_fuse_i} = 47'h0;
    {por_active_i, brownout_enable_i, brownout_low_i, scan_reset_reg_i} = 4'h0;
    {wdog_restart_i, wdog_always_on_fuse_i, adc_enable_i} = 3'h0;
    {rst_i, ext_reset_n_i, sel_i} = 6'h31;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rel();
    chk("delay", 1'b1, n >= DLY + 1 && n <= DLY + 3);
    rd(4'h0, 8'h01, "cause");
    wb(1'b1, 4'h0, 8'h00);
    rd(4'h0, 8'h00, "cause");
    brownout_enable_i <= 1'b1;
    pulse(0, 20, 1'b0);
    pulse(1, 30, 1'b0);
    pulse(0, 130, 1'b1);
    pulse(1, 110, 1'b1);
    pulse(2, 6, 1'b1);
    rd(4'h0, 8'h16, "cause");
    pulse(3, 6, 1'b1);
    rd(4'h0, 8'h01, "cause");
    chk("bandgap", 1'b1, bandgap_enable_o);
    {brownout_enable_i, adc_enable_i} <= 2'h1;
    repeat (2) @(posedge clk_i);
    chk("bandgap", 1'b1, bandgap_enable_o);
    adc_enable_i <= 1'b0;
    wb(1'b1, 4'h8, 8'h01);
    repeat (2) @(posedge clk_i);
    chk("bandgap", 1'b1, bandgap_enable_o);
    wb(1'b1, 4'h8, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("bandgap", 1'b0, bandgap_enable_o);
    rd(4'h4, 8'h00, "wdctl");
    wb(1'b1, 4'h4, 8'h08);
    rd(4'h4, 8'h08, "wdctl");
    wb(1'b1, 4'h4, 8'h00);
    rd(4'h4, 8'h08, "wdctl");
    wb(1'b1, 4'h4, 8'h18);
    wb(1'b1, 4'h4, 8'h00);
    rd(4'h4, 8'h00, "wdctl");
    wb(1'b1, 4'h4, 8'h08);
    wb(1'b1, 4'h4, 8'h18);
    repeat (6) @(posedge clk_i);
    wb(1'b1, 4'h4, 8'h00);
    rd(4'h4, 8'h08, "wdctl");
    n = 0;
    while (wdog_reset_o !== 1'b1 && n < 60000) begin
      @(posedge clk_i);
      n++;
    end
    chk("wdog_time", 1'b1, n > 48000 && n < 49400);
    rel();
    rd(4'h0, 8'h09, "cause");
    rd(4'h4, 8'h00, "wdctl");
    {wdog_always_on_fuse_i, rst_i} <= 2'h3;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rel();
    rd(4'h4, 8'h08, "wdctl");
    wb(1'b1, 4'h4, 8'h00);
    rd(4'h4, 8'h08, "wdctl");
    wb(1'b1, 4'h4, 8'h18);
    wb(1'b1, 4'h4, 8'h01);
    rd(4'h4, 8'h09, "wdctl");
    end_sim();
  end
endmodule

// [tb/reset_ctrl_monitor.sv]
// Port-level assertions for the reset controller.
module reset_ctrl_monitor #(
  parameter int unsigned DELAY_BASE_CYCLES = 4096
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic por_active_i,
  input wire logic ext_reset_n_i,
  input wire logic brownout_enable_i,
  input wire logic brownout_low_i,
  input wire logic scan_reset_reg_i,
  input wire logic adc_enable_i,
  input wire logic io_reset_o,
  input wire logic internal_reset_o,
  input wire logic wdog_reset_o,
  input wire logic bandgap_enable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        src;
  logic [15:0] quiet_cnt;
  // Raw sources are counted, so the bound is a floor that tolerates the input filters.
  assign src = por_active_i | ~ext_reset_n_i | (brownout_enable_i & brownout_low_i) | scan_reset_reg_i;
  always_ff @(posedge clk_i) begin
    if (rst_i || src || wdog_reset_o) quiet_cnt <= 16'h0000;
    else if (quiet_cnt != 16'hFFFF) quiet_cnt <= quiet_cnt + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_one_pulse;
    wdog_reset_o ##1 !wdog_reset_o;
  endsequence
  a_io_reset_src: assert property (src |-> io_reset_o)
    else $error("port reset missing while a source is active");
  a_hard_src_reset: assert property ((por_active_i || scan_reset_reg_i) [*4] |-> internal_reset_o)
    else $error("internal reset missing under power-on or scan reset");
  a_delay_stretch: assert property ($fell(internal_reset_o) |-> quiet_cnt >= DELAY_BASE_CYCLES)
    else $error("internal reset released before the delay ran out");
  a_wdog_pulse_one: assert property (wdog_reset_o |-> s_one_pulse)
    else $error("watchdog reset pulse longer than one cycle");
  a_wdog_stretch: assert property (wdog_reset_o |-> ##[0:2] internal_reset_o)
    else $error("watchdog pulse did not raise internal reset");
  a_bandgap_on: assert property (!internal_reset_o && (brownout_enable_i || adc_enable_i) |=> bandgap_enable_o)
    else $error("bandgap off while a user needs it");
  a_ack_one_wait: assert property (s_req |=> ack_o)
    else $error("bus answer not one cycle after the request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("bus answer held longer than one cycle");
endmodule

bind reset_and_watchdog_control reset_ctrl_monitor #(.DELAY_BASE_CYCLES(DELAY_BASE_CYCLES)) i_reset_ctrl_monitor (
  .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .por_active_i, .ext_reset_n_i, .brownout_enable_i, .brownout_low_i,
  .scan_reset_reg_i, .adc_enable_i, .io_reset_o, .internal_reset_o, .wdog_reset_o, .bandgap_enable_o);

// [tb/wdog_osc_model.sv]
// Free-running watchdog oscillator model.
module wdog_osc_model #(
  parameter int HALF_NS = 30
) (
  output logic osc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Runs faster than the real oscillator so that an expiry fits the run; still below half the system clock.
  initial begin
    osc_o = 1'b0;
    forever #HALF_NS osc_o = ~osc_o;
  end
endmodule
